// [rtl/fapd_ctrl.sv]
// auto powerdown controller for the floppy block with host register front
`timescale 1ns/1ps
`default_nettype none
module fapd_ctrl
	import fapd_pkg::*;
#(
	parameter int unsigned IDLE_CYCLES = TIMER_CYC
) (
	input  wire logic          clk,
	input  wire logic          rstn,
	input  wire fapd_host_type host,
	input  wire logic          auto_pd_en,
	input  wire logic [7:0]    ctl_status,
	input  wire logic          ctl_int,
	input  wire logic          head_unload_done,
	input  wire logic [7:0]    status_a_in,
	input  wire logic [7:0]    status_b_in,
	input  wire logic [7:0]    drive_in_in,
	input  wire logic [7:0]    data_in,
	input  wire fapd_fdd_type  fdd_core,
	input  wire logic          fdc_irq,
	input  wire logic          fdc_drq,
	output logic [7:0]         rd_data,
	output logic [7:0]         dor_eff,
	output logic [7:0]         dsr_eff,
	output logic [7:0]         ccr_eff,
	output logic               soft_reset,
	output logic               powered_down,
	output logic               pd_access,
	output logic               data_rd,
	output logic               data_wr,
	output logic [7:0]         data_wdata,
	output fapd_fdd_type       fdd_out,
	output logic               fdd_tri_oe,
	output logic               fdd_act_oe,
	output logic               host_interrupt_out,
	output logic               dma_request_out
);
	fapd_main_type s_r;
	fapd_main_type s_nxt;

	logic wake;
	logic soft_rst;
	logic dsr_pd_req;
	logic quiet;
	logic tmr_done;
	logic tmr_restart;
	logic motors_off;
	logic ctl_idle;
	logic cond_all;
	logic in_auto;

	fapd_wake_decode u_dec (
		.host       (host),
		.wake       (wake),
		.soft_rst   (soft_rst),
		.dsr_pd_req (dsr_pd_req),
		.quiet      (quiet)
	);

	// the timer is reloaded on every wake so a burst of host traffic
	// keeps the block up for a full idle period after the last waking access
	assign tmr_restart = wake;

	fapd_idle_timer #(
		.CYCLES (IDLE_CYCLES)
	) u_tmr (
		.clk     (clk),
		.rstn    (rstn),
		.run     (auto_pd_en),
		.restart (tmr_restart),
		.expired (tmr_done)
	);

	assign motors_off = s_r.drive_output_control[DOR_MOT_LSB +: 4] == 4'h0;
	// a polling interrupt can be pending with an idle status byte
	assign ctl_idle   = ctl_status == MSR_IDLE && !ctl_int;
	assign cond_all   = auto_pd_en && motors_off && ctl_idle &&
	                    head_unload_done && tmr_done;
	assign in_auto    = s_r.st == ST_AUTO_PD;

	always_comb begin
		s_nxt          = s_r;
		s_nxt.soft_rst = soft_rst;
		s_nxt.data_rd  = host.rd && host.addr == OFS_DATA;
		s_nxt.data_wr  = host.wr && host.addr == OFS_DATA;
		if (host.wr && host.addr == OFS_DATA) begin
			s_nxt.data_wdata = host.wdata;
		end

		// shadow copies always take host writes, even while down
		if (host.wr) begin
			unique case (host.addr)
				OFS_DOR: begin
					s_nxt.drive_output_control = host.wdata;
				end
				OFS_MSR: begin
					s_nxt.dsr = host.wdata & ~(8'h01 << DSR_RST_BIT);
				end
				OFS_DIR: begin
					s_nxt.rate_config_control = host.wdata;
				end
				default: begin
				end
			endcase
		end

		// reads show live state whatever the power state
		if (host.rd) begin
			unique case (host.addr)
				OFS_STA:  s_nxt.rd_data = status_a_in;
				OFS_STB:  s_nxt.rd_data = status_b_in;
				OFS_DOR:  s_nxt.rd_data = s_r.drive_output_control;
				OFS_MSR:  s_nxt.rd_data = ctl_status;
				OFS_DATA: s_nxt.rd_data = data_in;
				OFS_DIR:  s_nxt.rd_data = drive_in_in;
				default:  s_nxt.rd_data = 8'h00;
			endcase
		end

		unique case (s_r.st)
			ST_AWAKE: begin
				if (dsr_pd_req) begin
					s_nxt.st = ST_DSR_PD;
				end else if (cond_all && !wake) begin
					s_nxt.st = ST_AUTO_PD;
				end
			end
			ST_AUTO_PD: begin
				if (wake) begin
					s_nxt.st = ST_AWAKE;
				end else if (dsr_pd_req) begin
					s_nxt.st = ST_DSR_PD;
				end else if (!auto_pd_en) begin
					s_nxt.st = ST_AWAKE;
				end
			end
			ST_DSR_PD: begin
				// on wake the awake state re-arms the auto path
				if (wake) begin
					s_nxt.st = ST_AWAKE;
				end
			end
			default: begin
				s_nxt.st = ST_AWAKE;
			end
		endcase

		s_nxt.pd  = s_nxt.st != ST_AWAKE;
		s_nxt.svc = s_r.st != ST_AWAKE && quiet;

		// effective copies follow the shadows only while awake
		if (!s_nxt.pd) begin
			s_nxt.dor_eff = s_nxt.drive_output_control;
			s_nxt.dsr_eff = s_nxt.dsr;
			s_nxt.ccr_eff = s_nxt.rate_config_control;
		end

		s_nxt.fdd    = fdd_core;
		s_nxt.tri_oe = !s_nxt.pd;
		s_nxt.irq    = fdc_irq && !s_nxt.pd;
		s_nxt.drq    = fdc_drq && !s_nxt.pd;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_r.st         <= ST_AWAKE;
			s_r.drive_output_control        <= DOR_RST;
			s_r.dsr        <= DSR_RST;
			s_r.rate_config_control        <= CCR_RST;
			s_r.dor_eff    <= DOR_RST;
			s_r.dsr_eff    <= DSR_RST;
			s_r.ccr_eff    <= CCR_RST;
			s_r.rd_data    <= 8'h00;
			s_r.soft_rst   <= 1'b0;
			s_r.svc        <= 1'b0;
			s_r.pd         <= 1'b0;
			s_r.fdd        <= '0;
			s_r.tri_oe     <= 1'b1;
			s_r.irq        <= 1'b0;
			s_r.drq        <= 1'b0;
			s_r.data_rd    <= 1'b0;
			s_r.data_wr    <= 1'b0;
			s_r.data_wdata <= 8'h00;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rd_data            = s_r.rd_data;
	assign dor_eff            = s_r.dor_eff;
	assign dsr_eff            = s_r.dsr_eff;
	assign ccr_eff            = s_r.ccr_eff;
	assign soft_reset         = s_r.soft_rst;
	assign powered_down       = s_r.pd;
	assign pd_access          = s_r.svc;
	assign data_rd            = s_r.data_rd;
	assign data_wr            = s_r.data_wr;
	assign data_wdata         = s_r.data_wdata;
	assign fdd_out            = s_r.fdd;
	assign fdd_tri_oe         = s_r.tri_oe;
	// direction, step, head and density keep driving in powerdown
	assign fdd_act_oe         = 1'b1;
	assign host_interrupt_out = s_r.irq;
	assign dma_request_out    = s_r.drq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence msr_read_s;
		host.rd && host.addr == OFS_MSR;
	endsequence

	sequence data_touch_s;
		(host.rd || host.wr) && host.addr == OFS_DATA;
	endsequence

	sequence motor_write_s;
		host.wr && host.addr == OFS_DOR &&
			host.wdata[DOR_MOT_LSB +: 4] != 4'h0;
	endsequence

	auto_gate_a: assert property ($rose(in_auto) |->
		$past(auto_pd_en) && $past(motors_off) && $past(ctl_idle))
		else $error("auto powerdown entered without its conditions");
	auto_timer_a: assert property ($rose(in_auto) |->
		$past(head_unload_done) && $past(tmr_done))
		else $error("auto powerdown entered before timers expired");
	auto_entry_a: assert property (s_r.st == ST_AWAKE && cond_all &&
		!wake && !dsr_pd_req |=> in_auto)
		else $error("auto powerdown not entered when due");
	auto_cancel_a: assert property (!auto_pd_en |=> !in_auto)
		else $error("auto powerdown held with enable clear");
	dsr_over_a: assert property (in_auto && dsr_pd_req && !wake
		|=> s_r.st == ST_DSR_PD && powered_down)
		else $error("rate powerdown did not override");
	wake_msr_a: assert property (in_auto ##0 msr_read_s
		|=> !powered_down ##1 !tmr_done)
		else $error("status read did not wake and restart timer");
	wake_data_a: assert property (in_auto ##0 data_touch_s
		|=> !powered_down && s_r.st == ST_AWAKE)
		else $error("data access did not wake");
	wake_motor_a: assert property (in_auto ##0 motor_write_s
		|=> !powered_down && dor_eff[DOR_MOT_LSB +: 4] != 4'h0)
		else $error("motor enable write did not wake");
	quiet_stay_a: assert property (in_auto && quiet && !dsr_pd_req &&
		auto_pd_en |=> in_auto && pd_access ##1 !pd_access || wake)
		else $error("quiet access disturbed powerdown");
	quiet_keep_a: assert property (in_auto && quiet && host.wr &&
		host.addr == OFS_DIR && auto_pd_en |=> ccr_eff == $past(ccr_eff))
		else $error("quiet write applied while down");
	pins_off_a: assert property ($rose(in_auto) |-> !fdd_tri_oe &&
		fdd_act_oe)
		else $error("drive pins not tristated in powerdown");
	irq_low_a: assert property (powered_down |-> !host_interrupt_out &&
		!dma_request_out)
		else $error("interrupt or dma request active while down");

endmodule // fapd_ctrl
`default_nettype wire

// [common/fapd_pkg.sv]
// constants and carrier types for the floppy auto powerdown controller
`default_nettype none
package fapd_pkg;

	localparam int unsigned CLK_HZ     = 40_000_000;
	localparam int unsigned TIMER_MS   = 10;
	localparam int unsigned TIMER_CYC  = (CLK_HZ / 1000) * TIMER_MS;

	localparam logic [2:0] OFS_STA     = 3'h0;
	localparam logic [2:0] OFS_STB     = 3'h1;
	localparam logic [2:0] OFS_DOR     = 3'h2;
	localparam logic [2:0] OFS_MSR     = 3'h4;
	localparam logic [2:0] OFS_DATA    = 3'h5;
	localparam logic [2:0] OFS_DIR     = 3'h7;

	localparam logic [7:0] MSR_IDLE    = 8'h80;
	localparam int unsigned DOR_MOT_LSB = 4;
	localparam int unsigned DOR_NRST_BIT = 2;
	localparam int unsigned DSR_RST_BIT = 7;
	localparam int unsigned DSR_PD_BIT  = 6;

	localparam logic [7:0] DOR_RST     = 8'h04;
	localparam logic [7:0] DSR_RST     = 8'h02;
	localparam logic [7:0] CCR_RST     = 8'h02;

	typedef enum logic [2:0] {
		ST_AWAKE  = 3'b001,
		ST_AUTO_PD = 3'b010,
		ST_DSR_PD = 3'b100
	} fapd_state_type;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} fapd_host_type;

	typedef struct packed {
		logic [1:0] motor;
		logic [1:0] dsel;
		logic       wdata;
		logic       wgate;
		logic       dir;
		logic       step;
		logic       head;
		logic [1:0] dens;
	} fapd_fdd_type;

	typedef struct packed {
		fapd_state_type st;
		logic [7:0]     drive_output_control;
		logic [7:0]     dsr;
		logic [7:0]     rate_config_control;
		logic [7:0]     dor_eff;
		logic [7:0]     dsr_eff;
		logic [7:0]     ccr_eff;
		logic [7:0]     rd_data;
		logic           soft_rst;
		logic           svc;
		logic           pd;
		fapd_fdd_type   fdd;
		logic           tri_oe;
		logic           irq;
		logic           drq;
		logic           data_rd;
		logic           data_wr;
		logic [7:0]     data_wdata;
	} fapd_main_type;

endpackage
`default_nettype wire

// [rtl/fapd_idle_timer.sv]
// idle countdown that must run out before auto powerdown
`timescale 1ns/1ps
`default_nettype none
module fapd_idle_timer
	import fapd_pkg::*;
#(
	parameter int unsigned CYCLES = TIMER_CYC
) (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic run,
	input  wire logic restart,
	output logic      expired
);
	localparam int W = $clog2(CYCLES + 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} fapd_tmr_type;

	fapd_tmr_type s_r;
	fapd_tmr_type s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (!run || restart) begin
			s_nxt.cnt  = W'(CYCLES);
			s_nxt.done = 1'b0;
		end else if (s_r.cnt != '0) begin
			s_nxt.cnt  = s_r.cnt - 1'b1;
			s_nxt.done = (s_r.cnt == W'(1));
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_r.cnt  <= W'(CYCLES);
			s_r.done <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign expired = s_r.done;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	tmr_runout_a: assert property (run && !restart && s_r.cnt == W'(1)
		|=> expired) else $error("idle timer did not expire");
	tmr_cancel_a: assert property ((!run || restart) ##1 !restart
		|-> !expired) else $error("idle timer not cancelled");

endmodule // fapd_idle_timer
`default_nettype wire

// [rtl/fapd_wake_decode.sv]
// sorts host accesses into waking, resetting and quiet ones
`timescale 1ns/1ps
`default_nettype none
module fapd_wake_decode
	import fapd_pkg::*;
(
	input  wire fapd_host_type host,
	output logic               wake,
	output logic               soft_rst,
	output logic               dsr_pd_req,
	output logic               quiet
);
	logic dor_wr;
	logic dsr_wr;

	always_comb begin
		dor_wr     = host.wr && host.addr == OFS_DOR;
		dsr_wr     = host.wr && host.addr == OFS_MSR;
		soft_rst   = (dor_wr && !host.wdata[DOR_NRST_BIT]) ||
		             (dsr_wr && host.wdata[DSR_RST_BIT]);
		dsr_pd_req = dsr_wr && host.wdata[DSR_PD_BIT] && !soft_rst;
		wake       = soft_rst ||
		             (dor_wr && host.wdata[DOR_MOT_LSB +: 4] != 4'h0) ||
		             (host.rd && host.addr == OFS_MSR) ||
		             ((host.rd || host.wr) && host.addr == OFS_DATA);
		// above; everything else stays quiet
		quiet      = (host.rd || host.wr) && !wake;
	end

endmodule // fapd_wake_decode
`default_nettype wire

// [test/fapd_drive_model.sv]
// floppy drive side model: reports drive lines back as an input byte
`timescale 1ns/1ps
`default_nettype none
module fapd_drive_model
	import fapd_pkg::*;
(
	input  wire fapd_fdd_type pins,
	input  wire logic         tri_oe,
	output logic [7:0]        drive_in
);
	// released motor and select lines float up to their pull-ups
	assign drive_in = tri_oe ? {pins.motor, pins.dsel, 4'h0} : 8'hf0;
endmodule // fapd_drive_model
`default_nettype wire

// [test/test_fdc_auto_powerdown_ctrl.sv]
// self-checking bench for the auto powerdown controller
`timescale 1ns/1ps
`default_nettype none
module test_fdc_auto_powerdown_ctrl;
	import fapd_pkg::*;
	localparam int unsigned IDLE = 20;
	logic          clk, rstn, en, cint, hud, firq, fdrq;
	logic [7:0]    cst, rd_data, dor_eff, dsr_eff, ccr_eff, dwd, din;
	logic          srst, pd, pda, drd, dwr, toe, aoe, irq, drq;
	fapd_host_type host;
	fapd_fdd_type  core, pins;
	int            err_count, cmp_count;

	fapd_ctrl #(.IDLE_CYCLES(IDLE)) u_dut (.clk(clk), .rstn(rstn),
		.host(host), .auto_pd_en(en), .ctl_status(cst), .ctl_int(cint),
		.head_unload_done(hud), .status_a_in(8'h5a), .status_b_in(8'ha5),
		.drive_in_in(din), .data_in(8'h3c), .fdd_core(core),
		.fdc_irq(firq), .fdc_drq(fdrq), .rd_data(rd_data),
		.dor_eff(dor_eff), .dsr_eff(dsr_eff), .ccr_eff(ccr_eff),
		.soft_reset(srst), .powered_down(pd), .pd_access(pda),
		.data_rd(drd), .data_wr(dwr), .data_wdata(dwd), .fdd_out(pins),
		.fdd_tri_oe(toe), .fdd_act_oe(aoe), .host_interrupt_out(irq),
		.dma_request_out(drq));

	fapd_drive_model u_drv (.pins(pins), .tri_oe(toe), .drive_in(din));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic final_report;
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one-cycle strobe; outputs are settled at the negedge on which it returns
	task automatic acc(input logic r, w, input logic [2:0] a,
		input logic [7:0] d);
		@(negedge clk);
		host = '{rd: r, wr: w, addr: a, wdata: d};
		@(negedge clk);
		host = '0;
	endtask

	task automatic go_down;
		for (int i = 0; i < IDLE + 10 && pd !== 1'b1; i++) @(negedge clk);
		chk("powered_down", 8'h1, {7'h0, pd});
	endtask

	task automatic stay_up(input string nm, input int n);
		repeat (n) @(negedge clk);
		chk(nm, 8'h0, {7'h0, pd});
	endtask

	task automatic t_entry;
		chk("dor_eff", 8'h04, dor_eff);
		chk("ccr_eff", 8'h02, ccr_eff);
		chk("dsr_eff", 8'h02, dsr_eff);
		core = '1;
		stay_up("pd_disabled", IDLE + 5);
		chk("fdd_out", 8'hff, pins[10:3]);
		chk("irq_up", 8'h1, {7'h0, irq});
		chk("drq_up", 8'h1, {7'h0, drq});
		core = '0;
		en = 1'b1;
		stay_up("pd_early", IDLE - 3);
		go_down;
		chk("tri_oe", 8'h0, {7'h0, toe});
		chk("act_oe", 8'h1, {7'h0, aoe});
		chk("irq", 8'h0, {7'h0, irq});
		chk("drq", 8'h0, {7'h0, drq});
	endtask

	task automatic t_quiet;
		acc(1, 0, OFS_STA, 8'h00);
		chk("pd_access", 8'h1, {7'h0, pda});
		chk("sta", 8'h5a, rd_data);
		acc(1, 0, OFS_STB, 8'h00);
		chk("stb", 8'ha5, rd_data);
		acc(1, 0, OFS_DIR, 8'h00);
		chk("dir", 8'hf0, rd_data);
		acc(0, 1, OFS_DIR, 8'h01);
		chk("ccr_held", 8'h02, ccr_eff);
		acc(0, 1, OFS_DOR, 8'h0c);
		chk("pd_dor", 8'h1, {7'h0, pd});
		chk("pd_access_dor", 8'h1, {7'h0, pda});
		// the quiet pulse stands one cycle only
		@(negedge clk);
		chk("pd_access_end", 8'h0, {7'h0, pda});
		chk("pd_after_quiet", 8'h1, {7'h0, pd});
		acc(1, 0, OFS_MSR, 8'h00);
		chk("pd_msr", 8'h0, {7'h0, pd});
		chk("msr", 8'h80, rd_data);
		chk("ccr_wake", 8'h01, ccr_eff);
		chk("dor_wake", 8'h0c, dor_eff);
		stay_up("pd_rearm", IDLE - 3);
		go_down;
	endtask

	task automatic t_wake;
		acc(1, 0, OFS_DOR, 8'h00);
		chk("pd_dor_rd", 8'h1, {7'h0, pd});
		acc(0, 1, OFS_DOR, 8'h1c);
		chk("pd_motor", 8'h0, {7'h0, pd});
		stay_up("pd_motor_on", IDLE + 5);
		acc(0, 1, OFS_DOR, 8'h0c);
		go_down;
		acc(1, 0, OFS_DATA, 8'h00);
		chk("data_rd", 8'h1, {7'h0, drd});
		chk("data", 8'h3c, rd_data);
		go_down;
		acc(0, 1, OFS_DATA, 8'h77);
		chk("data_wr", 8'h1, {7'h0, dwr});
		chk("data_wdata", 8'h77, dwd);
		cint = 1'b1;
		stay_up("pd_int", IDLE + 5);
		cint = 1'b0;
		hud = 1'b0;
		stay_up("pd_hud", IDLE + 5);
		hud = 1'b1;
		cst = 8'h90;
		stay_up("pd_busy", IDLE + 5);
		cst = 8'h80;
		go_down;
	endtask

	task automatic t_modes;
		en = 1'b0;
		stay_up("pd_off", IDLE + 5);
		en = 1'b1;
		go_down;
		acc(0, 1, OFS_MSR, 8'h40);
		en = 1'b0;
		repeat (IDLE + 5) @(negedge clk);
		chk("pd_rate", 8'h1, {7'h0, pd});
		en = 1'b1;
		acc(1, 0, OFS_MSR, 8'h00);
		chk("pd_rate_wake", 8'h0, {7'h0, pd});
		chk("dsr_wake", 8'h40, dsr_eff);
		go_down;
		acc(0, 1, OFS_MSR, 8'h80);
		chk("srst_dsr", 8'h1, {7'h0, srst});
		chk("pd_srst", 8'h0, {7'h0, pd});
		go_down;
		acc(0, 1, OFS_DOR, 8'h00);
		chk("srst_dor", 8'h1, {7'h0, srst});
		go_down;
		rstn = 1'b0;
		@(negedge clk);
		chk("pd_hwrst", 8'h0, {7'h0, pd});
		chk("dor_hwrst", 8'h04, dor_eff);
		rstn = 1'b1;
		stay_up("pd_after_rst", IDLE - 3);
	endtask

	initial begin
		host = '0;
		core = '0;
		en = 1'b0;
		cint = 1'b0;
		hud = 1'b1;
		cst = 8'h80;
		firq = 1'b1;
		fdrq = 1'b1;
		rstn = 1'b0;
		err_count = 0;
		cmp_count = 0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		t_entry;
		t_quiet;
		t_wake;
		t_modes;
		final_report;
	end

	// run needs well under 1500 cycles; this cuts a hang short
	initial begin
		#(25 * 4000);
		err_count++;
		final_report;
	end
endmodule // test_fdc_auto_powerdown_ctrl
`default_nettype wire
